// file: hss_consts.vh
/*
 * Constants for the serial command register bank of the quad high side switch.
 * Assumes inclusion by the bank module only; holds definitions and nothing else.
 */
`ifndef HSS_CONSTS_VH
`define HSS_CONSTS_VH

`define HSS_WORD_BITS        16
`define HSS_WDOG_BIT         15
`define HSS_CHAN_HI          14
`define HSS_CHAN_LO          13
`define HSS_RSEL_HI          12
`define HSS_RSEL_LO          10
`define HSS_PAY_HI           8

`define HSS_RSEL_STATUS      3'h0
`define HSS_RSEL_DUTY        3'h1
`define HSS_RSEL_SWITCH      3'h2
`define HSS_RSEL_FAULT       3'h3
`define HSS_RSEL_OCUR        3'h4
`define HSS_RSEL_GLOBAL      3'h5
`define HSS_RSEL_CAL         3'h7

`define HSS_REG_RESET        9'h000
`define HSS_DUTY_FULL        7'h7F
`define HSS_DUTY_ON_BIT      7

`define HSS_FCFG_ON_OPENLOAD_DISABLE    3
`define HSS_FCFG_OFF_OPENLOAD_DISABLE   2
`define HSS_FCFG_LED_SEL     1
`define HSS_FCFG_GAIN        0

`define HSS_GCFG_VDDFAIL_EN  8
`define HSS_GCFG_TEMP_EN     5
`define HSS_GCFG_SENSE_EN    4
`define HSS_GCFG_SENSE_HI    3
`define HSS_GCFG_SENSE_LO    2

`define HSS_CLK_NS           100
`define HSS_LED_PERIOD_NS    1000000
`define HSS_LED_CYCLES       (`HSS_LED_PERIOD_NS / `HSS_CLK_NS)

`endif

// file: hss_cmd_regs.v
/*
 * Serial command receiver, configuration register bank and diagnostic
 * flag latching for a four-channel high side switch.
 * Assumes the serial pins, the analog comparator results and the supply
 * monitors arrive asynchronously; all are synchronised to CORE_CLK, which
 * must run well above the serial clock.
 * The serial clock must stay high and low for at least three CORE_CLK
 * periods each, and CS_N must stay high that long between frames.
 * No status data is returned here; only the read select is stored.
 */
//
// Contract
// - Off channel above off threshold latches off open-load flag after gate off.
// - Status read clears off open-load flag only when condition has gone.
// - Per-channel bit suppresses off-state open-load detection.
// - Per-channel bit selects bulb or LED on-state threshold.
// - Low on-state current sets on flag; output and fault pin untouched.
// - LED mode samples once per period, only fully on with duty 7F.
// - On flag clears after condition gone and a read; bit disables detection.
// - Sense routing set by configuration; current copy off in fail-safe.
// - Normal mode latches temperature prewarning; a status read or a supply clear resets it.
// - Supply clamp cancels protective turn-off and forces all outputs on.
// - Logic supply fail with enable set resets all serial registers.
// - Power loss with good logic supply keeps configuration, reports undervoltage.
// - Both supplies below power-on level clear registers and latched faults.
// - Commands are 16-bit words shifted in most significant bit first.
// - Bits 14:13 channel, 12:10 register, 8:0 payload; bit 9 zero.
// - Frames of multiples of 16 bits accepted; other lengths ignored.
// - Register codes map as listed; global and calibration need channel 00.
// - Channel code selects output 0 to 3 for per-channel registers.
`timescale 1ns/1ps
`include "hss_consts.vh"

module hss_cmd_regs #(
    parameter LED_CYCLES = `HSS_LED_CYCLES
) (
    input  wire       CORE_CLK,
    input  wire       SYS_RST,
    input  wire       SCLK,
    input  wire       CS_N,
    input  wire       SDI,
    input  wire [3:0] OFF_OPENLOAD_COND,
    input  wire [3:0] GATE_OFF,
    input  wire [3:0] ON_BULB_LOW,
    input  wire [3:0] ON_LED_LOW,
    input  wire       OVERTEMP_WARN,
    input  wire       CLAMP_ACTIVE,
    input  wire       LOGIC_SUPPLY_FAIL,
    input  wire       POWER_SUPPLY_LOW,
    input  wire       POR_LOW,
    input  wire       FAIL_SAFE,
    input  wire [3:0] DIRECT_IN,
    input  wire [3:0] PROTECT_OFF,
    output reg  [3:0] HIGH_SIDE_OUTPUT,
    output reg  [3:0] OFF_OPENLOAD_FLAG,
    output reg  [3:0] ON_OPENLOAD_FLAG,
    output reg        OVERTEMP_PREWARNING_FLAG,
    output reg        UNDERVOLTAGE_FLAG,
    output reg        SENSE_OUTPUT_ENABLE,
    output reg        TEMP_SENSE_ENABLE,
    output reg  [1:0] SENSE_CHANNEL_SELECT,
    output reg        SENSE_GAIN_SELECT,
    output reg  [4:0] STATUS_CONTENT_SELECT,
    output reg        WATCHDOG_TOGGLE_BIT,
    output reg        CMD_STROBE,
    output reg  [8:0] GLOBAL_CONFIG,
    output reg  [8:0] OSCILLATOR_CALIBRATION
);

    // Synchronisers: every asynchronous input passes two flip-flops.
    // Bit positions of each input inside the synchroniser word.
    localparam P_PROT  = 0;
    localparam P_DIR   = 4;
    localparam P_FSAFE = 8;
    localparam P_POR   = 9;
    localparam P_PWR   = 10;
    localparam P_LFAIL = 11;
    localparam P_CLAMP = 12;
    localparam P_OTW   = 13;
    localparam P_LED   = 14;
    localparam P_BULB  = 18;
    localparam P_GATE  = 22;
    localparam P_OFF   = 26;
    localparam P_SDI   = 30;
    localparam P_CS    = 31;
    localparam P_SCLK  = 32;
    localparam NSYNC   = 33;
    // CS_N resets to its idle high level, so that the release of reset
    // is never mistaken for the close of a frame.
    localparam [NSYNC-1:0] SYNC_IDLE = 33'h0_8000_0000;
    wire [NSYNC-1:0] async_in = {SCLK, CS_N, SDI, OFF_OPENLOAD_COND, GATE_OFF,
                                 ON_BULB_LOW, ON_LED_LOW, OVERTEMP_WARN, CLAMP_ACTIVE,
                                 LOGIC_SUPPLY_FAIL, POWER_SUPPLY_LOW, POR_LOW,
                                 FAIL_SAFE, DIRECT_IN, PROTECT_OFF};
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire       s_sclk     = sync2_reg[P_SCLK];
    wire       s_cs_n     = sync2_reg[P_CS];
    wire       s_sdi      = sync2_reg[P_SDI];
    wire [3:0] s_offcond  = sync2_reg[P_OFF+3:P_OFF];
    wire [3:0] s_gateoff  = sync2_reg[P_GATE+3:P_GATE];
    wire [3:0] s_bulblow  = sync2_reg[P_BULB+3:P_BULB];
    wire [3:0] s_ledlow   = sync2_reg[P_LED+3:P_LED];
    wire       s_otw      = sync2_reg[P_OTW];
    wire       s_clamp    = sync2_reg[P_CLAMP];
    wire       s_lfail    = sync2_reg[P_LFAIL];
    wire       s_pwrlow   = sync2_reg[P_PWR];
    wire       s_por      = sync2_reg[P_POR];
    wire       s_failsafe = sync2_reg[P_FSAFE];
    wire [3:0] s_direct   = sync2_reg[P_DIR+3:P_DIR];
    wire [3:0] s_protoff  = sync2_reg[P_PROT+3:P_PROT];

    // Serial receiver, sampled on rising serial clock edges.
    reg        sclk_d_reg;
    reg        cs_n_d_reg;
    reg [15:0] shift_reg;
    reg [3:0]  bitcnt_reg;
    reg        first_reg;

    wire sclk_rise = s_sclk & ~sclk_d_reg;
    wire frame_end = s_cs_n & ~cs_n_d_reg;
    // A frame is only latched when its length is a whole number of words.
    wire frame_ok  = frame_end & ~first_reg & (bitcnt_reg == 4'h0);
    // The 4-bit count wraps every 16 rises, so any multiple of 16 ends at zero.
    // A frame with no clock at all also ends at zero; first_reg refuses it.

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
            shift_reg  <= 16'h0000;
            bitcnt_reg <= 4'h0;
            first_reg  <= 1'b1;
        end else begin
            sclk_d_reg <= s_sclk;
            cs_n_d_reg <= s_cs_n;
            if (s_cs_n) begin
                bitcnt_reg <= 4'h0;
                first_reg  <= 1'b1;
            end else if (sclk_rise) begin
                shift_reg  <= {shift_reg[14:0], s_sdi};
                bitcnt_reg <= bitcnt_reg + 4'h1;
                first_reg  <= 1'b0;
            end
        end
    end

    // The last word shifted in is the one addressed to this device.
    // Payload bit 9 is not checked; a frame with it set is taken as if clear.
    wire [1:0] chan = shift_reg[`HSS_CHAN_HI:`HSS_CHAN_LO];
    wire [2:0] rsel = shift_reg[`HSS_RSEL_HI:`HSS_RSEL_LO];
    wire [8:0] pay  = shift_reg[`HSS_PAY_HI:0];

    // Register storage, one 9-bit word per channel.
    // Unused payload bits are stored as sent, so a read-back shows them.
    reg [8:0] duty_reg   [0:3];
    reg [8:0] swcfg_reg  [0:3];
    reg [8:0] fltcfg_reg [0:3];
    reg [8:0] ocur_reg   [0:3];
    reg [4:0] stsel_reg;

    // Supply clears act two cycles after the pin, the synchroniser delay.
    wire vdd_reset = s_lfail & GLOBAL_CONFIG[`HSS_GCFG_VDDFAIL_EN];
    wire reg_clear = s_por | vdd_reset;
    // A status read is any accepted frame with code 000, whatever the channel.
    wire status_rd = frame_ok & (rsel == `HSS_RSEL_STATUS);
    integer i;

    always @(posedge CORE_CLK) begin
        if (SYS_RST || reg_clear) begin
            for (i = 0; i < 4; i = i + 1) begin
                duty_reg[i]   <= `HSS_REG_RESET;
                swcfg_reg[i]  <= `HSS_REG_RESET;
                fltcfg_reg[i] <= `HSS_REG_RESET;
                ocur_reg[i]   <= `HSS_REG_RESET;
            end
            stsel_reg              <= 5'h00;
            GLOBAL_CONFIG          <= `HSS_REG_RESET;
            OSCILLATOR_CALIBRATION <= `HSS_REG_RESET;
            WATCHDOG_TOGGLE_BIT    <= 1'b0;
            CMD_STROBE             <= 1'b0;
        end else begin
            // Power loss alone does not touch the configuration.
            CMD_STROBE <= frame_ok;
            if (frame_ok) begin
                // Only recorded here; judging the toggle is left to the supervisor.
                WATCHDOG_TOGGLE_BIT <= shift_reg[`HSS_WDOG_BIT];
                case (rsel)
                    `HSS_RSEL_STATUS: begin
                        stsel_reg <= pay[4:0];
                    end
                    `HSS_RSEL_DUTY: begin
                        duty_reg[chan] <= pay;
                    end
                    `HSS_RSEL_SWITCH: begin
                        swcfg_reg[chan] <= pay;
                    end
                    `HSS_RSEL_FAULT: begin
                        fltcfg_reg[chan] <= pay;
                    end
                    `HSS_RSEL_OCUR: begin
                        ocur_reg[chan] <= pay;
                    end
                    `HSS_RSEL_GLOBAL: begin
                        if (chan == 2'b00) begin
                            GLOBAL_CONFIG <= pay;
                        end
                    end
                    `HSS_RSEL_CAL: begin
                        if (chan == 2'b00) begin
                            OSCILLATOR_CALIBRATION <= pay;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // LED sampling timer; counts free and fires once per period.
    // One shared timer saves area; a channel that turns fully on mid-period
    // therefore waits between one and two periods for its first sample.
    reg [31:0] led_cnt_reg;
    wire       led_tick = (led_cnt_reg == LED_CYCLES - 1);

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            led_cnt_reg <= 32'h0000_0000;
        end else if (led_tick) begin
            led_cnt_reg <= 32'h0000_0000;
        end else begin
            led_cnt_reg <= led_cnt_reg + 32'h0000_0001;
        end
    end

    // Next value of a sticky flag word: the set wins over a clear, and a
    // status read clears only those bits whose cause has gone away.
    function [3:0] sticky_next;
        input [3:0] flags;
        input [3:0] set;
        input [3:0] cause;
        input       rd;
        begin
            sticky_next = set | (flags & ~({4{rd}} & ~cause));
        end
    endfunction

    // Diagnostics per channel. The comparator inputs are levels; the flags
    // are sticky, and only supply clears and status reads take them down.
    // A channel counts as commanded on from its on bit or its direct input.
    reg [3:0] on_cmd;
    reg [3:0] on_seen_reg;
    reg [3:0] off_set;
    reg [3:0] on_set;
    reg [3:0] full_on;
    integer c;
    integer k;

    always @* begin
        for (c = 0; c < 4; c = c + 1) begin
            on_cmd[c]  = duty_reg[c][`HSS_DUTY_ON_BIT] | s_direct[c];
            full_on[c] = on_cmd[c] & (duty_reg[c][6:0] == `HSS_DUTY_FULL);
            off_set[c] = ~on_cmd[c] & s_offcond[c] & s_gateoff[c]
                         & ~fltcfg_reg[c][`HSS_FCFG_OFF_OPENLOAD_DISABLE];
            if (fltcfg_reg[c][`HSS_FCFG_ON_OPENLOAD_DISABLE]) begin
                on_set[c] = 1'b0;
            end else if (fltcfg_reg[c][`HSS_FCFG_LED_SEL]) begin
                // Needs a full period on before a sample can count.
                on_set[c] = led_tick & full_on[c] & on_seen_reg[c] & s_ledlow[c];
            end else begin
                on_set[c] = on_cmd[c] & s_bulblow[c];
            end
        end
    end

    always @(posedge CORE_CLK) begin
        if (SYS_RST || s_por || vdd_reset) begin
            OFF_OPENLOAD_FLAG        <= 4'h0;
            ON_OPENLOAD_FLAG         <= 4'h0;
            OVERTEMP_PREWARNING_FLAG <= 1'b0;
            UNDERVOLTAGE_FLAG        <= 1'b0;
            on_seen_reg              <= 4'h0;
        end else begin
            // on_seen_reg remembers that a tick has already occurred while fully on.
            for (k = 0; k < 4; k = k + 1) begin
                if (!full_on[k]) begin
                    on_seen_reg[k] <= 1'b0;
                end else if (led_tick) begin
                    on_seen_reg[k] <= 1'b1;
                end
            end
            OFF_OPENLOAD_FLAG <= sticky_next(OFF_OPENLOAD_FLAG, off_set,
                                             s_offcond, status_rd);
            ON_OPENLOAD_FLAG  <= sticky_next(ON_OPENLOAD_FLAG, on_set,
                                             s_bulblow | s_ledlow, status_rd);
            OVERTEMP_PREWARNING_FLAG <= (s_otw & ~s_failsafe) |
                                        (OVERTEMP_PREWARNING_FLAG & ~status_rd);
            UNDERVOLTAGE_FLAG <= s_pwrlow | (UNDERVOLTAGE_FLAG & ~status_rd);
        end
    end

    // Outputs and sense routing. On-open-load never affects the outputs.
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            HIGH_SIDE_OUTPUT      <= 4'h0;
            SENSE_OUTPUT_ENABLE   <= 1'b0;
            TEMP_SENSE_ENABLE     <= 1'b0;
            SENSE_CHANNEL_SELECT  <= 2'b00;
            SENSE_GAIN_SELECT     <= 1'b0;
            STATUS_CONTENT_SELECT <= 5'h00;
        end else begin
            // The clamp overrides protective turn-off so the line can demagnetise.
            if (s_clamp) begin
                HIGH_SIDE_OUTPUT <= 4'hF;
            end else begin
                HIGH_SIDE_OUTPUT <= on_cmd & ~s_protoff;
            end
            SENSE_OUTPUT_ENABLE  <= GLOBAL_CONFIG[`HSS_GCFG_SENSE_EN] & ~s_failsafe;
            TEMP_SENSE_ENABLE    <= GLOBAL_CONFIG[`HSS_GCFG_TEMP_EN];
            SENSE_CHANNEL_SELECT <= GLOBAL_CONFIG[`HSS_GCFG_SENSE_HI:`HSS_GCFG_SENSE_LO];
            SENSE_GAIN_SELECT    <= fltcfg_reg[GLOBAL_CONFIG[`HSS_GCFG_SENSE_HI:
                                    `HSS_GCFG_SENSE_LO]][`HSS_FCFG_GAIN];
            STATUS_CONTENT_SELECT <= stsel_reg;
        end
    end

endmodule

// file: hss_cmd_regs_monitor.sv
/* Concurrent checks on the ports of the command register bank.
   Assumes a bind onto hss_cmd_regs, all ports sampled on CORE_CLK. */
`timescale 1ns/1ps
module hss_cmd_regs_monitor #(
    parameter LED_CYCLES = 8
) (
    input wire logic       CORE_CLK,
    input wire logic       SYS_RST,
    input wire logic       CS_N,
    input wire logic       CLAMP_ACTIVE,
    input wire logic       POR_LOW,
    input wire logic       LOGIC_SUPPLY_FAIL,
    input wire logic       POWER_SUPPLY_LOW,
    input wire logic       OVERTEMP_WARN,
    input wire logic       FAIL_SAFE,
    input wire logic [3:0] HIGH_SIDE_OUTPUT,
    input wire logic [3:0] OFF_OPENLOAD_FLAG,
    input wire logic [3:0] ON_OPENLOAD_FLAG,
    input wire logic       OVERTEMP_PREWARNING_FLAG,
    input wire logic       UNDERVOLTAGE_FLAG,
    input wire logic       WATCHDOG_TOGGLE_BIT,
    input wire logic       CMD_STROBE,
    input wire logic [8:0] GLOBAL_CONFIG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // Supply clears pass two sync flops, so their cause is remembered a few cycles.
    logic [3:0] sup_hist;
    logic       sup_hit;
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sup_hist <= 4'h0;
        end else begin
            sup_hist <= {sup_hist[2:0], POR_LOW | LOGIC_SUPPLY_FAIL};
        end
    end
    assign sup_hit = (|sup_hist) | POR_LOW | LOGIC_SUPPLY_FAIL;
    a_strobe_one_cycle: assert property (CMD_STROBE |=> !CMD_STROBE)
        else $error("strobe longer than one cycle");
    a_strobe_after_frame: assert property (CMD_STROBE |-> $past(CS_N, 2) && $past(CS_N, 3))
        else $error("strobe without closed frame");
    a_clamp_all_on: assert property (CLAMP_ACTIVE [*4] |-> HIGH_SIDE_OUTPUT == 4'hF)
        else $error("clamp did not force outputs on");
    a_por_clears_all: assert property (POR_LOW [*4] |-> GLOBAL_CONFIG == 9'h000
        && {OFF_OPENLOAD_FLAG, ON_OPENLOAD_FLAG, OVERTEMP_PREWARNING_FLAG} == 9'h000)
        else $error("power-on clear incomplete");
    a_uv_reported: assert property ((POWER_SUPPLY_LOW && !POR_LOW) [*4] |-> UNDERVOLTAGE_FLAG)
        else $error("supply loss not reported");
    a_warn_latched: assert property ((OVERTEMP_WARN && !FAIL_SAFE && !sup_hit) [*4]
        |-> OVERTEMP_PREWARNING_FLAG) else $error("prewarning not latched");
    a_warn_sticky: assert property ($fell(OVERTEMP_PREWARNING_FLAG)
        |-> CMD_STROBE || $past(CMD_STROBE) || sup_hit) else $error("prewarning lost");
    a_onflag_keeps_out: assert property ($rose(|ON_OPENLOAD_FLAG) && !CMD_STROBE
        |-> $stable(HIGH_SIDE_OUTPUT)) else $error("on open-load changed output");
    a_config_by_cmd: assert property ($changed(GLOBAL_CONFIG) || $changed(WATCHDOG_TOGGLE_BIT)
        |-> CMD_STROBE || sup_hit) else $error("register changed without frame");
    a_offflag_sticky: assert property (($past(OFF_OPENLOAD_FLAG) & ~OFF_OPENLOAD_FLAG) != 4'h0
        |-> CMD_STROBE || $past(CMD_STROBE) || sup_hit) else $error("off flag lost");
    a_onflag_sticky: assert property (($past(ON_OPENLOAD_FLAG) & ~ON_OPENLOAD_FLAG) != 4'h0
        |-> CMD_STROBE || $past(CMD_STROBE) || sup_hit) else $error("on flag lost");
endmodule
bind hss_cmd_regs hss_cmd_regs_monitor #(.LED_CYCLES(LED_CYCLES)) i_mon (.*);

// file: hss_host_model.sv
/* Behavioural host that shifts command frames into the bank.
   Assumes CORE_CLK timing; the serial clock stands low between frames. */
`timescale 1ns/1ps
module hss_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    logic wd;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        wd = 1'b0;
    end
    // Leading filler bits model daisy chained traffic ahead of the word.
    task automatic send(input logic [14:0] w, input int lead, output logic wdo);
        logic [15:0] word;
        wd = ~wd;
        word = {wd, w[14:10], 1'b0, w[8:0]};
        wdo = wd;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = lead + 15; i >= 0; i--) begin
            sclk <= 1'b0;
            sdi <= (i > 15) ? i[0] : word[i[3:0]];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: hss_cmd_regs_test.sv
/* Self-checking bench for the command register bank.
   Assumes the host model owns the serial pins; the bench drives the rest. */
`timescale 1ns/1ps
module hss_cmd_regs_test;
    localparam int LEDC = 8;
    logic       CORE_CLK, SYS_RST, SCLK, CS_N, SDI, OVERTEMP_WARN, CLAMP_ACTIVE, FAIL_SAFE;
    logic       LOGIC_SUPPLY_FAIL, POWER_SUPPLY_LOW, POR_LOW, WATCHDOG_TOGGLE_BIT, CMD_STROBE;
    logic [3:0] OFF_OPENLOAD_COND, GATE_OFF, ON_BULB_LOW, ON_LED_LOW, DIRECT_IN, PROTECT_OFF;
    logic [3:0] HIGH_SIDE_OUTPUT, OFF_OPENLOAD_FLAG, ON_OPENLOAD_FLAG;
    logic       OVERTEMP_PREWARNING_FLAG, UNDERVOLTAGE_FLAG, SENSE_OUTPUT_ENABLE;
    logic       TEMP_SENSE_ENABLE, SENSE_GAIN_SELECT, wdx;
    logic [1:0] SENSE_CHANNEL_SELECT;
    logic [4:0] STATUS_CONTENT_SELECT;
    logic [8:0] GLOBAL_CONFIG, OSCILLATOR_CALIBRATION;
    int         errors = 0, checked = 0, cycles = 0, strobes = 0, s;
    hss_cmd_regs #(.LED_CYCLES(LEDC)) i_dut (.*);
    hss_host_model i_host (.clk(CORE_CLK), .sclk(SCLK), .cs_n(CS_N), .sdi(SDI));
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask
    task automatic wr(input logic [1:0] ch, input logic [2:0] rs, input logic [8:0] pay,
                      input int lead = 0);
        i_host.send({ch, rs, 1'b0, pay}, lead, wdx);
        @(negedge CORE_CLK);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The run should need about 3300 cycles; the ceiling leaves wide margin.
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (CMD_STROBE === 1'b1) strobes <= strobes + 1;
        if (cycles == 30000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        SYS_RST = 1'b1;
        {OVERTEMP_WARN, CLAMP_ACTIVE, LOGIC_SUPPLY_FAIL, POWER_SUPPLY_LOW, POR_LOW, FAIL_SAFE} = 6'h00;
        {OFF_OPENLOAD_COND, GATE_OFF, ON_BULB_LOW, ON_LED_LOW, DIRECT_IN, PROTECT_OFF} = 24'h00_0000;
        repeat (3) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        settle(1);
        check(16'({GLOBAL_CONFIG, HIGH_SIDE_OUTPUT}), 16'h0000);
        check(16'(OSCILLATOR_CALIBRATION), 16'h0000);
        $display("reset test done");
        wr(2'h0, 3'h5, 9'h134);
        check(16'(GLOBAL_CONFIG), 16'h0134);
        check(16'({TEMP_SENSE_ENABLE, SENSE_OUTPUT_ENABLE, SENSE_CHANNEL_SELECT}), 16'h000D);
        check(16'(WATCHDOG_TOGGLE_BIT), 16'(wdx));
        @(posedge CORE_CLK) FAIL_SAFE <= 1'b1;
        settle(6);
        check(16'(SENSE_OUTPUT_ENABLE), 16'h0000);
        @(posedge CORE_CLK) FAIL_SAFE <= 1'b0;
        wr(2'h1, 3'h5, 9'h0FF);
        check(16'(GLOBAL_CONFIG), 16'h0134);
        wr(2'h0, 3'h7, 9'h15B);
        wr(2'h2, 3'h7, 9'h000);
        check(16'(OSCILLATOR_CALIBRATION), 16'h015B);
        wr(2'h0, 3'h0, 9'h015);
        check(16'(STATUS_CONTENT_SELECT), 16'h0015);
        for (int c = 0; c < 4; c++) begin
            wr(c[1:0], 3'h1, 9'h080, (c == 3) ? 16 : 0);
            check(16'(HIGH_SIDE_OUTPUT), 16'((1 << (c + 1)) - 1));
        end
        s = strobes;
        wr(2'h0, 3'h1, 9'h000, 1);
        check(16'({strobes[3:0], HIGH_SIDE_OUTPUT}), 16'({s[3:0], 4'hF}));
        $display("command test done");
        @(posedge CORE_CLK) PROTECT_OFF <= 4'hF;
        settle(6);
        check(16'(HIGH_SIDE_OUTPUT), 16'h0000);
        @(posedge CORE_CLK) CLAMP_ACTIVE <= 1'b1;
        settle(6);
        check(16'(HIGH_SIDE_OUTPUT), 16'h000F);
        @(posedge CORE_CLK) {CLAMP_ACTIVE, PROTECT_OFF} <= 5'h00;
        wr(2'h3, 3'h1, 9'h000);
        @(posedge CORE_CLK) OFF_OPENLOAD_COND <= 4'h8;
        settle(6);
        check(16'(OFF_OPENLOAD_FLAG), 16'h0000);
        @(posedge CORE_CLK) GATE_OFF <= 4'h8;
        settle(6);
        check(16'(OFF_OPENLOAD_FLAG), 16'h0008);
        wr(2'h0, 3'h0, 9'h000);
        check(16'(OFF_OPENLOAD_FLAG), 16'h0008);
        @(posedge CORE_CLK) OFF_OPENLOAD_COND <= 4'h0;
        settle(6);
        wr(2'h0, 3'h0, 9'h000);
        check(16'(OFF_OPENLOAD_FLAG), 16'h0000);
        wr(2'h3, 3'h3, 9'h004);
        @(posedge CORE_CLK) OFF_OPENLOAD_COND <= 4'h8;
        settle(6);
        check(16'(OFF_OPENLOAD_FLAG), 16'h0000);
        @(posedge CORE_CLK) {OFF_OPENLOAD_COND, GATE_OFF, ON_BULB_LOW} <= 12'h001;
        settle(6);
        check(16'({HIGH_SIDE_OUTPUT, ON_OPENLOAD_FLAG}), 16'h0071);
        wr(2'h0, 3'h0, 9'h000);
        check(16'(ON_OPENLOAD_FLAG), 16'h0001);
        @(posedge CORE_CLK) ON_BULB_LOW <= 4'h0;
        settle(6);
        wr(2'h0, 3'h0, 9'h000);
        check(16'(ON_OPENLOAD_FLAG), 16'h0000);
        wr(2'h0, 3'h3, 9'h008);
        @(posedge CORE_CLK) ON_BULB_LOW <= 4'h1;
        settle(6);
        check(16'(ON_OPENLOAD_FLAG), 16'h0000);
        wr(2'h1, 3'h3, 9'h003);
        check(16'(SENSE_GAIN_SELECT), 16'h0001);
        @(posedge CORE_CLK) {ON_BULB_LOW, ON_LED_LOW} <= 8'h22;
        settle(3 * LEDC + 6);
        check(16'(ON_OPENLOAD_FLAG), 16'h0000);
        wr(2'h1, 3'h1, 9'h0FF);
        settle(3 * LEDC + 6);
        check(16'(ON_OPENLOAD_FLAG), 16'h0002);
        @(posedge CORE_CLK) {ON_BULB_LOW, ON_LED_LOW, OVERTEMP_WARN} <= 9'h001;
        settle(6);
        @(posedge CORE_CLK) OVERTEMP_WARN <= 1'b0;
        settle(6);
        check(16'(OVERTEMP_PREWARNING_FLAG), 16'h0001);
        wr(2'h0, 3'h0, 9'h000);
        check(16'({OVERTEMP_PREWARNING_FLAG, ON_OPENLOAD_FLAG}), 16'h0000);
        $display("diagnostic test done");
        @(posedge CORE_CLK) POWER_SUPPLY_LOW <= 1'b1;
        settle(6);
        check(16'({UNDERVOLTAGE_FLAG, 3'h0, GLOBAL_CONFIG}), 16'h1134);
        @(posedge CORE_CLK) {POWER_SUPPLY_LOW, LOGIC_SUPPLY_FAIL, DIRECT_IN} <= 6'h15;
        settle(6);
        check(16'({GLOBAL_CONFIG, HIGH_SIDE_OUTPUT}), 16'h0005);
        @(posedge CORE_CLK) {LOGIC_SUPPLY_FAIL, DIRECT_IN, OVERTEMP_WARN} <= 6'h01;
        wr(2'h0, 3'h5, 9'h0FF);
        @(posedge CORE_CLK) {OVERTEMP_WARN, POR_LOW} <= 2'h1;
        settle(6);
        @(posedge CORE_CLK) POR_LOW <= 1'b0;
        settle(6);
        check(16'({GLOBAL_CONFIG, OVERTEMP_PREWARNING_FLAG}), 16'h0000);
        $display("supply test done");
        test_done;
    end
endmodule
